// ---- rtl/dllsw_map.svh ----
// Purpose: offsets, field positions, latencies and timing counts
// Assumes: 20 MHz clock, 50 ns period; counts are in clock cycles
// Notes: times without a printed figure carry plain defaults
`ifndef DLLSW_MAP_SVH
`define DLLSW_MAP_SVH
`define DLLSW_CLK_PERIOD_NS 50
// mode register field positions
`define DLLSW_MODE_ONE_DLL_OFF_BIT 0
`define DLLSW_MODE_ZERO_DLL_RESET_BIT 8
`define DLLSW_MODE_ZERO_READ_LAT_LSB 4
`define DLLSW_MODE_ZERO_READ_LAT_BASE 4
`define DLLSW_MODE_TWO_WRITE_LAT_LSB 3
`define DLLSW_MODE_TWO_WRITE_LAT_BASE 5
`define DLLSW_NOM_TERM_BIT_A 2
`define DLLSW_NOM_TERM_BIT_B 6
`define DLLSW_NOM_TERM_BIT_C 9
`define DLLSW_WR_TERM_BIT_A 9
`define DLLSW_WR_TERM_BIT_B 10
`define DLLSW_PRECHARGE_ALL_BIT 10
// bank address values that select a mode register
`define DLLSW_SEL_MODE_ZERO 2'h0
`define DLLSW_SEL_MODE_ONE 2'h1
`define DLLSW_SEL_MODE_TWO 2'h2
// latencies
`define DLLSW_ADDITIVE_LATENCY 0
`define DLLSW_OFF_READ_LATENCY 6
`define DLLSW_OFF_WRITE_LATENCY 6
`define DLLSW_ON_READ_LATENCY 7
`define DLLSW_ON_WRITE_LATENCY 6
// timing counts in cycles
`define DLLSW_MODE_SET_GAP_CK 4
`define DLLSW_MODE_UPDATE_DELAY_CK 12
`define DLLSW_SR_ENTRY_HOLD_CK 5
`define DLLSW_SR_EXIT_SETUP_CK 5
`define DLLSW_SR_EXIT_DELAY_CK 10
`define DLLSW_PRECHARGE_CK 3
`define DLLSW_ACT_TO_CMD_CK 3
`define DLLSW_IMPCAL_LONG_CK 256
`define DLLSW_DLL_LOCK_CK 512
`define DLLSW_VREF_WRITE_GAP_CK 512
// strobe access window upper bound, longest time rounds down, floor one
`define DLLSW_STROBE_MAX_NS 10
`define DLLSW_STROBE_WIN_CK (((`DLLSW_STROBE_MAX_NS / `DLLSW_CLK_PERIOD_NS) > 0) ? \
  (`DLLSW_STROBE_MAX_NS / `DLLSW_CLK_PERIOD_NS) : 1)
`endif

// ---- rtl/dllsw_pkg.sv ----
// Purpose: command type shared by both ends, state type used by the controller
// Assumes: command word is {cs_n, ras_n, cas_n, we_n}
// Notes: none
package dllsw_pkg;
  typedef enum logic [3:0] {
    CMD_MRS   = 4'h0,
    CMD_REF   = 4'h1,
    CMD_PRE   = 4'h2,
    CMD_ACT   = 4'h3,
    CMD_WR    = 4'h4,
    CMD_RD    = 4'h5,
    CMD_ZQ    = 4'h6,
    CMD_NOP   = 4'h7,
    CMD_DESEL = 4'h8
  } dllsw_cmd_type;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ACT = 4'h1, ST_RW = 4'h2, ST_CAPT = 4'h3,
    ST_PRE = 4'h4, ST_OFFMR1 = 4'h5, ST_SRE = 4'h6, ST_SRSTAB = 4'h7,
    ST_SRX = 4'h8, ST_MR1 = 4'h9, ST_MR0 = 4'hA, ST_MR2 = 4'hB,
    ST_ZQ = 4'hC, ST_WAIT = 4'hD
  } dllsw_state_type;
endpackage

// ---- rtl/dllsw_if.sv ----
// Purpose: command, address and data link between controller and memory
// Assumes: both ends share clk
// Notes: shared data bus resolved here from the two enables
`timescale 1ns/1ps
`default_nettype none
interface dllsw_if #(parameter int DW = 8) (input wire logic clk);
  dllsw_pkg::dllsw_cmd_type cmd_n;  // {cs_n, ras_n, cas_n, we_n}
  logic          cke;                 // clock enable
  logic [2:0]    ba;                  // bank address
  logic [13:0]   addr;                // row, column or mode value
  logic          termination_control_input;
  logic          clk_rate_slow;       // clock generator rate select
  logic [DW-1:0] dq_ctl_o;            // controller write data
  logic          dq_ctl_oe;
  logic          data_mask_line;
  logic [DW-1:0] dq_dev_o;            // memory read data
  logic          dq_dev_oe;
  logic          dqs_dev;             // read strobe, high with data
  logic [DW-1:0] dq;                  // resolved bus level
  // idle bus reads as zero so nobody sees an undriven value
  assign dq = dq_ctl_oe ? dq_ctl_o : (dq_dev_oe ? dq_dev_o : '0);
  modport ctrl (
    input  dq, dqs_dev,
    output cmd_n, cke, ba, addr, termination_control_input, clk_rate_slow,
    output dq_ctl_o, dq_ctl_oe, data_mask_line
  );
  modport dram (
    input  cmd_n, cke, ba, addr, termination_control_input, clk_rate_slow,
    input  dq, data_mask_line,
    output dq_dev_o, dq_dev_oe, dqs_dev
  );
endinterface
`default_nettype wire

// ---- rtl/dllsw_dram.sv ----
// Purpose: memory end: mode registers, self refresh, latency-timed access
// Assumes: one-word bursts; rows are not stored, index is {bank, column}
// Notes: contents are never touched while in self refresh
`timescale 1ns/1ps
`default_nettype none
`include "dllsw_map.svh"
module dllsw_dram #(
  parameter int MEM_AW = 6,
  parameter int DW     = 8
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  dllsw_if.dram      bus,
  output logic       dll_off,
  output logic       in_self_refresh,
  output logic       clock_ignored,
  output logic       rate_fault,
  output logic       termination_on,
  output logic [4:0] read_latency
);
  import dllsw_pkg::*;
  localparam int         DEPTH   = 2 ** MEM_AW;
  localparam logic [4:0] ADD_LAT = 5'(`DLLSW_ADDITIVE_LATENCY);
  localparam logic [4:0] OFF_RL  = 5'(`DLLSW_OFF_READ_LATENCY);
  localparam logic [4:0] OFF_WL  = 5'(`DLLSW_OFF_WRITE_LATENCY);
  localparam logic [4:0] RD_BASE = 5'(`DLLSW_MODE_ZERO_READ_LAT_BASE);
  localparam logic [4:0] WR_BASE = 5'(`DLLSW_MODE_TWO_WRITE_LAT_BASE);
  localparam logic [3:0] HOLD_CK = 4'(`DLLSW_SR_ENTRY_HOLD_CK);
  if (MEM_AW < 4 || MEM_AW > 13 || DW < 1) begin : g_bad_param
    $error("dllsw_dram: MEM_AW must be 4..13 and DW positive");
  end
  logic [DW-1:0]     mem [DEPTH];  // storage, no reset
  logic [13:0]       mode_zero;    // read latency field, dll reset
  logic [13:0]       mode_one;     // dll off bit, nominal termination
  logic [13:0]       mode_two;     // write latency field
  logic              cke_q;        // clock enable one cycle ago
  logic              rate_q;       // rate select one cycle ago
  logic [3:0]        hold_cnt;     // cycles since self refresh entry
  logic [7:0]        bank_open;    // one bit per bank
  logic [4:0]        write_latency;
  logic [4:0]        rd_cnt;       // read countdown
  logic [4:0]        wr_cnt;       // write countdown
  logic [MEM_AW-1:0] rd_idx;
  logic [MEM_AW-1:0] wr_idx;
  logic [MEM_AW-1:0] idx;          // index of the current command
  logic              live;         // command is decoded this cycle
  dllsw_cmd_type     cmd;
  assign cmd  = bus.cmd_n;
  assign idx  = {bus.ba, bus.addr[MEM_AW-4:0]};
  // only self refresh entry is decoded across a clock enable edge; no command is decoded in self refresh
  assign live = bus.cke && cke_q && !in_self_refresh;
  // previous-cycle copies of the link levels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cke_q  <= 1'b0;
      rate_q <= 1'b0;
    end else begin
      cke_q  <= bus.cke;
      rate_q <= bus.clk_rate_slow;
    end
  end
  // mode register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_zero <= '0;
      mode_one  <= '0;
      mode_two  <= '0;
      dll_off   <= 1'b0;
    end else if (live && cmd == CMD_MRS) begin
      unique case (bus.ba[1:0])
        `DLLSW_SEL_MODE_ZERO: mode_zero <= bus.addr;
        `DLLSW_SEL_MODE_ONE: begin
          mode_one <= bus.addr;
          dll_off  <= bus.addr[`DLLSW_MODE_ONE_DLL_OFF_BIT];
        end
        `DLLSW_SEL_MODE_TWO: mode_two <= bus.addr;
        default: ;  // fourth register not modelled
      endcase
    end
  end
  // latencies in use; dll off forces the single supported pair
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      read_latency  <= ADD_LAT + OFF_RL;
      write_latency <= OFF_WL;
    end else if (dll_off) begin
      read_latency  <= ADD_LAT + OFF_RL - 5'h01;
      write_latency <= OFF_WL;
    end else begin
      read_latency  <= ADD_LAT + RD_BASE + 5'(mode_zero[`DLLSW_MODE_ZERO_READ_LAT_LSB +: 3]);
      write_latency <= WR_BASE + 5'(mode_two[`DLLSW_MODE_TWO_WRITE_LAT_LSB +: 3]);
    end
  end
  // self refresh entry on refresh with clock enable falling, exit on rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_self_refresh <= 1'b0;
      hold_cnt        <= '0;
      clock_ignored   <= 1'b0;
    end else if (!in_self_refresh) begin
      clock_ignored <= 1'b0;
      hold_cnt      <= '0;
      if (cke_q && !bus.cke && cmd == CMD_REF) begin
        in_self_refresh <= 1'b1;
      end
    end else if (bus.cke) begin
      in_self_refresh <= 1'b0;
      clock_ignored   <= 1'b0;
    end else if (hold_cnt != HOLD_CK - 4'h1) begin  // the refresh cycle already had cke low
      hold_cnt <= hold_cnt + 4'h1;
    end else begin
      clock_ignored <= 1'b1;
    end
  end
  // sticky: rate moved while the clock still mattered; cleared by reset only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_fault <= 1'b0;
    end else if (bus.clk_rate_slow != rate_q && !clock_ignored) begin
      rate_fault <= 1'b1;
    end
  end
  // termination only acts with the dll on and a nonzero nominal field
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      termination_on <= 1'b0;
    end else begin
      termination_on <= bus.termination_control_input && !dll_off &&
                        (mode_one[`DLLSW_NOM_TERM_BIT_A] || mode_one[`DLLSW_NOM_TERM_BIT_B] ||
                         mode_one[`DLLSW_NOM_TERM_BIT_C]);
    end
  end
  // open bank tracking; precharge-all clears every bank
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bank_open <= '0;
    end else if (live && cmd == CMD_ACT) begin
      bank_open[bus.ba] <= 1'b1;
    end else if (live && cmd == CMD_PRE) begin
      if (bus.addr[`DLLSW_PRECHARGE_ALL_BIT]) begin
        bank_open <= '0;
      end else begin
        bank_open[bus.ba] <= 1'b0;
      end
    end
  end
  // read: data and strobe appear read_latency cycles after the command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_cnt <= '0;
      rd_idx <= '0;
    end else if (live && cmd == CMD_RD && bank_open[bus.ba]) begin
      rd_cnt <= read_latency - 5'h01;
      rd_idx <= idx;
    end else if (rd_cnt != 5'h00) begin
      rd_cnt <= rd_cnt - 5'h01;
    end
  end
  // outputs stay released outside the read beat, refresh included
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus.dq_dev_oe <= 1'b0;
      bus.dqs_dev   <= 1'b0;
      bus.dq_dev_o  <= '0;
    end else begin
      bus.dq_dev_oe <= (rd_cnt == 5'h01);
      bus.dqs_dev   <= (rd_cnt == 5'h01);
      bus.dq_dev_o  <= (rd_cnt == 5'h01) ? mem[rd_idx] : '0;
    end
  end
  // write: same path with dll on or off, data sampled write_latency later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_cnt <= '0;
      wr_idx <= '0;
    end else if (live && cmd == CMD_WR && bank_open[bus.ba]) begin
      wr_cnt <= write_latency;
      wr_idx <= idx;
    end else if (wr_cnt != 5'h00) begin
      wr_cnt <= wr_cnt - 5'h01;
    end
  end
  // storage update; masked beats leave the word alone
  always_ff @(posedge clk) begin
    if (wr_cnt == 5'h01 && !bus.data_mask_line) begin
      mem[wr_idx] <= bus.dq;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/dllsw_ctrl.sv ----
// Purpose: controller end: accesses and dll on/off switching via self refresh
// Assumes: one outstanding access; each access opens and closes its row
// Notes: reset runs the dll-on mode program before the first access
`timescale 1ns/1ps
`default_nettype none
`include "dllsw_map.svh"
module dllsw_ctrl #(
  parameter int DW          = 8,
  parameter int DLL_LOCK_CK = `DLLSW_DLL_LOCK_CK,
  parameter int IMPCAL_CK   = `DLLSW_IMPCAL_LONG_CK,
  parameter int VREF_GAP_CK = `DLLSW_VREF_WRITE_GAP_CK
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  dllsw_if.ctrl              bus,
  input  wire logic          req_valid,
  input  wire logic          req_write,
  input  wire logic [2:0]    req_bank,
  input  wire logic [13:0]   req_row,
  input  wire logic [9:0]    req_col,
  input  wire logic [DW-1:0] req_wdata,
  input  wire logic          req_mask,
  input  wire logic          dll_off_req,
  input  wire logic          vref_floated,
  output logic               req_ready,
  output logic               rsp_valid,
  output logic               rsp_timeout,
  output logic [DW-1:0]      rsp_rdata,
  output logic               dll_off_state,
  output logic               switching,
  output logic               dll_locked
);
  import dllsw_pkg::*;
  localparam logic [9:0] GAP_CK    = 10'(`DLLSW_MODE_SET_GAP_CK);
  localparam logic [9:0] UPD_CK    = 10'(`DLLSW_MODE_UPDATE_DELAY_CK);
  localparam logic [9:0] MODSET_CK = (GAP_CK > UPD_CK) ? GAP_CK : UPD_CK;
  localparam logic [9:0] ENTRY_CK  = 10'(`DLLSW_SR_ENTRY_HOLD_CK);
  localparam logic [9:0] SETUP_CK  = 10'(`DLLSW_SR_EXIT_SETUP_CK);
  localparam logic [9:0] EXITD_CK  = 10'(`DLLSW_SR_EXIT_DELAY_CK);
  localparam logic [9:0] PRE_CK    = 10'(`DLLSW_PRECHARGE_CK);
  localparam logic [9:0] ACT_CK    = 10'(`DLLSW_ACT_TO_CMD_CK);
  localparam logic [9:0] IMP_CK    = 10'(IMPCAL_CK);
  localparam logic [9:0] LOCK_CK   = 10'(DLL_LOCK_CK);
  localparam logic [9:0] VREF_CK   = 10'(VREF_GAP_CK);
  localparam logic [4:0] ADD_LAT   = 5'(`DLLSW_ADDITIVE_LATENCY);
  localparam logic [4:0] OFF_RL    = 5'(`DLLSW_OFF_READ_LATENCY);
  localparam logic [4:0] OFF_WL    = 5'(`DLLSW_OFF_WRITE_LATENCY);
  localparam logic [4:0] ON_RL     = 5'(`DLLSW_ON_READ_LATENCY);
  localparam logic [4:0] ON_WL     = 5'(`DLLSW_ON_WRITE_LATENCY);
  localparam logic [4:0] RD_BASE   = 5'(`DLLSW_MODE_ZERO_READ_LAT_BASE);
  localparam logic [4:0] WR_BASE   = 5'(`DLLSW_MODE_TWO_WRITE_LAT_BASE);
  localparam logic [4:0] WIN       = 5'(`DLLSW_STROBE_WIN_CK);
  if (DW < 1 || DLL_LOCK_CK < 1 || DLL_LOCK_CK > 1023 || IMPCAL_CK < 1 ||
      IMPCAL_CK > 1023 || VREF_GAP_CK < 1 || VREF_GAP_CK > 1023) begin : g_bad_param
    $error("dllsw_ctrl: counts must be 1..1023 and DW positive");
  end
  dllsw_state_type state;       // current step
  dllsw_state_type ret_state;   // step after the wait
  logic [9:0]      wait_cnt;    // cycles left in ST_WAIT
  logic            target_off;  // dll mode being programmed
  logic [4:0]      cyc;         // cycles since read or write command
  logic            is_write;
  logic            mask_q;
  logic [9:0]      col_q;
  logic [9:0]      lock_cnt;    // cycles until dll lock
  logic [9:0]      vref_cnt;    // cycles until writes allowed
  logic [4:0]      rd_exp;      // first cycle a strobe is accepted
  logic [4:0]      wr_lat;
  logic [4:0]      tgt_rl;      // read latency to program; the field gets this less RD_BASE
  logic [4:0]      tgt_wl;
  logic            may_access;
  // latency and capture alignment follow the current dll mode flag
  assign rd_exp = dll_off_state ? ADD_LAT + OFF_RL - 5'h01 : ADD_LAT + ON_RL;
  assign wr_lat = dll_off_state ? OFF_WL : ON_WL;
  assign tgt_rl = target_off ? OFF_RL : ON_RL;
  assign tgt_wl = target_off ? OFF_WL : ON_WL;
  // the dll must be locked before any access in dll-on mode
  assign may_access = (dll_off_state || lock_cnt == 10'h000) &&
                      !(req_write && vref_cnt != 10'h000);
  // dll lock timer, started by each dll reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_cnt   <= LOCK_CK;
      dll_locked <= 1'b0;
    end else begin
      dll_locked <= (lock_cnt == 10'h000);
      if (state == ST_MR0 && !target_off) begin
        lock_cnt <= LOCK_CK;
      end else if (lock_cnt != 10'h000) begin
        lock_cnt <= lock_cnt - 10'h001;
      end
    end
  end
  // reference may have floated in self refresh; count from the exit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vref_cnt <= '0;
    end else if (state == ST_SRX && vref_floated) begin
      vref_cnt <= VREF_CK;
    end else if (vref_cnt != 10'h000) begin
      vref_cnt <= vref_cnt - 10'h001;
    end
  end
  // sequencer and command bus
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state          <= ST_MR1;  // program dll-on mode first
      ret_state      <= ST_IDLE;
      wait_cnt       <= '0;
      target_off     <= 1'b0;
      cyc            <= '0;
      is_write       <= 1'b0;
      mask_q         <= 1'b0;
      col_q          <= '0;
      switching      <= 1'b1;
      dll_off_state  <= 1'b0;
      req_ready      <= 1'b0;
      rsp_valid      <= 1'b0;
      rsp_timeout    <= 1'b0;
      rsp_rdata      <= '0;
      bus.cmd_n      <= CMD_NOP;
      bus.cke        <= 1'b1;
      bus.ba         <= '0;
      bus.addr       <= '0;
      bus.clk_rate_slow  <= 1'b0;
      bus.dq_ctl_o       <= '0;
      bus.dq_ctl_oe      <= 1'b0;
      bus.data_mask_line <= 1'b0;
      bus.termination_control_input <= 1'b0;
    end else begin
      bus.cmd_n   <= CMD_NOP;
      req_ready   <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_timeout <= 1'b0;
      bus.termination_control_input <= 1'b0;
      unique case (state)
        ST_WAIT: begin
          if (wait_cnt <= 10'h001) begin
            state <= ret_state;
          end else begin
            wait_cnt <= wait_cnt - 10'h001;
          end
        end
        ST_IDLE: begin
          if (dll_off_req != dll_off_state) begin
            target_off <= dll_off_req;
            switching  <= 1'b1;
            state      <= ST_PRE;
          end else if (req_valid && may_access) begin
            switching    <= 1'b0;
            req_ready    <= 1'b1;
            is_write     <= req_write;
            mask_q       <= req_mask;
            col_q        <= req_col;
            bus.dq_ctl_o <= req_wdata;
            bus.cmd_n    <= CMD_ACT;
            bus.ba       <= req_bank;
            bus.addr     <= req_row;
            wait_cnt     <= ACT_CK;
            ret_state    <= ST_RW;
            state        <= ST_WAIT;
          end else begin
            switching <= 1'b0;
          end
        end
        ST_RW: begin
          bus.cmd_n <= is_write ? CMD_WR : CMD_RD;
          bus.addr  <= {4'h0, col_q};  // precharge-all bit low: no auto precharge
          cyc       <= 5'h01;
          state     <= ST_CAPT;
        end
        ST_CAPT: begin
          cyc <= cyc + 5'h01;
          if (is_write) begin
            // cyc runs one ahead of the cycle count, so this drives exactly wr_lat after the command
            bus.dq_ctl_oe      <= (cyc == wr_lat);
            bus.data_mask_line <= (cyc == wr_lat) && mask_q;
            if (cyc == wr_lat + 5'h01) begin
              state <= ST_PRE;
            end
          end else if (bus.dqs_dev && cyc >= rd_exp && cyc <= rd_exp + WIN) begin
            rsp_rdata <= bus.dq;
            rsp_valid <= 1'b1;
            state     <= ST_PRE;
          end else if (cyc > rd_exp + WIN) begin
            rsp_timeout <= 1'b1;
            state       <= ST_PRE;
          end
        end
        ST_PRE: begin
          bus.cmd_n <= CMD_PRE;
          bus.addr  <= '0;
          bus.addr[`DLLSW_PRECHARGE_ALL_BIT] <= 1'b1;
          wait_cnt  <= PRE_CK;
          ret_state <= !switching ? ST_IDLE : (target_off ? ST_OFFMR1 : ST_SRE);
          state     <= ST_WAIT;
        end
        ST_OFFMR1: begin
          bus.cmd_n <= CMD_MRS;
          bus.ba    <= {1'b0, `DLLSW_SEL_MODE_ONE};
          bus.addr  <= '0;  // nominal termination bits stay zero
          bus.addr[`DLLSW_MODE_ONE_DLL_OFF_BIT] <= 1'b1;
          wait_cnt  <= UPD_CK;
          ret_state <= ST_SRE;
          state     <= ST_WAIT;
        end
        ST_SRE: begin
          bus.cke   <= 1'b0;
          bus.cmd_n <= CMD_REF;
          wait_cnt  <= ENTRY_CK;
          ret_state <= ST_SRSTAB;
          state     <= ST_WAIT;
        end
        ST_SRSTAB: begin
          bus.clk_rate_slow <= target_off;
          wait_cnt  <= SETUP_CK;
          ret_state <= ST_SRX;
          state     <= ST_WAIT;
        end
        ST_SRX: begin
          bus.cke   <= 1'b1;
          wait_cnt  <= EXITD_CK;
          ret_state <= target_off ? ST_MR0 : ST_MR1;
          state     <= ST_WAIT;
        end
        ST_MR1: begin
          bus.cmd_n <= CMD_MRS;
          bus.ba    <= {1'b0, `DLLSW_SEL_MODE_ONE};
          bus.addr  <= '0;  // dll on, termination off
          wait_cnt  <= GAP_CK;
          ret_state <= ST_MR0;
          state     <= ST_WAIT;
        end
        ST_MR0: begin
          bus.cmd_n <= CMD_MRS;
          bus.ba    <= {1'b0, `DLLSW_SEL_MODE_ZERO};
          bus.addr  <= '0;
          bus.addr[`DLLSW_MODE_ZERO_READ_LAT_LSB +: 3] <= 3'(tgt_rl - RD_BASE);
          bus.addr[`DLLSW_MODE_ZERO_DLL_RESET_BIT] <= !target_off;
          wait_cnt  <= GAP_CK;
          ret_state <= ST_MR2;
          state     <= ST_WAIT;
        end
        ST_MR2: begin
          bus.cmd_n     <= CMD_MRS;
          bus.ba        <= {1'b0, `DLLSW_SEL_MODE_TWO};
          bus.addr      <= '0;  // write termination bits stay zero
          bus.addr[`DLLSW_MODE_TWO_WRITE_LAT_LSB +: 3] <= 3'(tgt_wl - WR_BASE);
          dll_off_state <= target_off;
          wait_cnt      <= MODSET_CK;
          ret_state     <= ST_ZQ;
          state         <= ST_WAIT;
        end
        ST_ZQ: begin
          bus.cmd_n <= CMD_ZQ;
          bus.addr  <= '0;
          bus.addr[`DLLSW_PRECHARGE_ALL_BIT] <= 1'b1;  // long calibration form
          wait_cnt  <= IMP_CK;
          ret_state <= ST_IDLE;
          state     <= ST_WAIT;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- dv/dllsw_sva.sv ----
// Purpose: checker on the link between controller and memory
// Assumes: one clock, reset synchronous and active low
// Notes: read beat range spans both dll modes, the checker cannot see the mode
`timescale 1ns/1ps
`default_nettype none
module dllsw_sva (
  input wire logic               clk,
  input wire logic               rst_n,
  input var dllsw_pkg::dllsw_cmd_type cmd_n,
  input wire logic               cke,
  input wire logic [13:0]        addr,
  input wire logic               termination_control_input,
  input wire logic               clk_rate_slow,
  input wire logic               dq_ctl_oe,
  input wire logic               dq_dev_oe,
  input wire logic               dqs_dev
);
  import dllsw_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_CKE_HIGH: assert property ((cmd_n == CMD_ACT || cmd_n == CMD_PRE) |-> cke)
    else $error("clock enable low at activate or precharge");
  AST_PRE_ALL: assert property (cmd_n == CMD_PRE |-> addr[10])
    else $error("precharge without all-banks bit");
  AST_REF_DQ_IDLE: assert property (cmd_n == CMD_REF |-> !dq_ctl_oe && !dq_dev_oe)
    else $error("data bus driven at refresh");
  AST_TERM_LOW: assert property (!termination_control_input)
    else $error("termination control driven high");
  AST_RATE_IN_SR: assert property ($changed(clk_rate_slow) |-> !cke && !$past(cke, 4))
    else $error("clock rate changed outside self refresh hold");
  AST_SR_HOLD: assert property (cmd_n == CMD_REF && !cke |=> (!cke) [*8])
    else $error("self refresh left too early");
  AST_MRS_GAP: assert property (cmd_n == CMD_MRS |=> (cmd_n == CMD_NOP) [*4])
    else $error("command inside mode set gap");
  AST_READ_BEAT: assert property (cmd_n == CMD_RD |-> ##[5:7] (dqs_dev && dq_dev_oe))
    else $error("read beat outside latency window");
  AST_WR_DATA: assert property (cmd_n == CMD_WR |-> ##6 dq_ctl_oe)
    else $error("write data not at write latency");
  cover property (cmd_n == CMD_WR);
  cover property ($rose(clk_rate_slow));
  cover property ($fell(clk_rate_slow));
endmodule
`default_nettype wire

// ---- dv/test_dram_dll_off_mode_switching.sv ----
// Purpose: random accesses across dll on/off switches, checked against a model
// Assumes: small lock, calibration and reference counts to keep the run short
// Notes: only written locations are read back
`timescale 1ns/1ps
`default_nettype none
module test_dram_dll_off_mode_switching;
  import dllsw_pkg::*;
  logic        clk = 0, rst_n = 0, req_valid = 0, req_write = 0, req_mask = 0;
  logic        dll_off_req = 0, vref_floated = 0;
  logic [2:0]  req_bank = 0;
  logic [13:0] req_row = 0;
  logic [9:0]  req_col = 0;
  logic [7:0]  req_wdata = 0, rsp_rdata, mem [int];
  logic        req_ready, rsp_valid, rsp_timeout, dll_off_state, switching;
  logic        dll_off, rate_fault, termination_on, in_sr, clk_ign, dll_locked;
  logic [4:0]  read_latency;
  int          err_count = 0, checked = 0, n;
  always #25 clk = ~clk;
  dllsw_if dllsw_if_inst (.clk);
  dllsw_ctrl #(.DLL_LOCK_CK(16), .IMPCAL_CK(8), .VREF_GAP_CK(16)) dllsw_ctrl_inst (.clk, .rst_n,
    .bus(dllsw_if_inst.ctrl), .req_valid, .req_write, .req_bank, .req_row, .req_col, .req_wdata,
    .req_mask, .dll_off_req, .vref_floated, .req_ready, .rsp_valid, .rsp_timeout, .rsp_rdata,
    .dll_off_state, .switching, .dll_locked);
  dllsw_dram dllsw_dram_inst (.clk, .rst_n, .bus(dllsw_if_inst.dram), .dll_off,
    .in_self_refresh(in_sr), .clock_ignored(clk_ign), .rate_fault, .termination_on, .read_latency);
  dllsw_sva dllsw_sva_inst (.clk, .rst_n, .cmd_n(dllsw_if_inst.cmd_n), .cke(dllsw_if_inst.cke),
    .addr(dllsw_if_inst.addr), .termination_control_input(dllsw_if_inst.termination_control_input),
    .clk_rate_slow(dllsw_if_inst.clk_rate_slow), .dq_ctl_oe(dllsw_if_inst.dq_ctl_oe),
    .dq_dev_oe(dllsw_if_inst.dq_dev_oe), .dqs_dev(dllsw_if_inst.dqs_dev));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d of %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // a wait that used up its bound is a hang
  task automatic hang(input int cnt);
    if (cnt >= 4000) begin
      err_count++;
      close_out();
    end
  endtask
  // one random access; unwritten places are always written first
  task automatic access;
    logic [5:0] idx;
    idx = 6'($urandom);
    @(posedge clk);
    req_valid <= 1;
    req_write <= !mem.exists(idx) || $urandom % 2;
    req_bank <= idx[5:3];
    req_col <= {7'($urandom), idx[2:0]};
    req_row <= 14'($urandom);
    req_wdata <= 8'($urandom);
    req_mask <= mem.exists(idx) && ($urandom % 4 == 0);
    for (n = 0; n < 4000 && req_ready !== 1; n++) @(negedge clk);
    hang(n);
    @(posedge clk) req_valid <= 0;
    if (req_write) begin
      if (!req_mask) mem[idx] = req_wdata;
    end else begin
      for (n = 0; n < 4000 && rsp_valid !== 1 && rsp_timeout !== 1; n++) @(negedge clk);
      hang(n);
      chk("read data", {1'b0, mem[idx]}, {rsp_timeout, rsp_rdata});
    end
  endtask
  // ask for a mode and wait until the switch sequence has finished
  task automatic switch_to(input logic off);
    @(posedge clk) dll_off_req <= off;
    vref_floated <= 1'($urandom);
    for (n = 0; n < 4000 && !(dll_off_state === off && switching === 0); n++) @(negedge clk);
    hang(n);
    chk("mode", {off, 5'(off ? 5 : 7)}, {dll_off, read_latency});
    chk("flags", 3'h1, {in_sr, clk_ign, dll_locked});
  endtask
  initial begin
    void'($urandom(32'h9926));
    repeat (4) @(posedge clk);
    rst_n <= 1;
    for (int k = 0; k < 6; k++) begin
      switch_to(1'(k % 2));
      repeat (12) access();
    end
    chk("faults", 0, {rate_fault, termination_on});
    close_out();
  end
endmodule
`default_nettype wire
